// ### hw/csc_device.sv
// Operation
// - Reset copies whole stored image into RAM
// - Host edits RAM; RAM is active configuration
// - Stored image programmable once, then refused
// - Host: pause, write, validate, lock, restart, calibrate
// - Host read-modify-writes partially masked registers
// - Blank device configured fully by host writes
// - Divider alternates neighbours, residue keeps zero error
// - Four banks, two equal-frequency outputs each
// - Bank frequency set per bank, reference unchanged
// - Crystal free-run or lock to reference
// - Lock loss when detector inputs differ 1000ppm
// - Status at 218 names interrupt cause
`timescale 1ns/1ps
module csc_device
    import csc_pkg::*;
#(
    parameter int ACQ_LEN = ACQ_CYCLES,
    parameter int LOS_LEN = LOS_CYCLES
) (
    input  wire logic                              i_sys_clk,
    input  wire logic                              i_reset_n,
    csc_cfg_if.dev                                 bus,
    input  wire logic                              i_xtal_tick,
    input  wire logic                              i_ref_tick,
    input  wire logic                              i_pfd_ref_tick,
    input  wire logic                              i_pfd_fb_tick,
    output logic [BANKS*OUTS_PER_BANK-1:0]         o_bank_clk,
    output logic                                   o_intr,
    output logic                                   o_input_xtal,
    output logic                                   o_lock_loss_monitor_en
);
    initial begin
        if (ACQ_LEN < 1 || ACQ_LEN > 65535 || LOS_LEN < 1 || LOS_LEN > 65535) begin
            $error("csc_device: timing parameter out of range");
        end
    end

    typedef struct packed {
        csc_dev_state_t           st;
        logic [ADDR_W-1:0]        idx;
        logic                     ack;
        logic                     err;
        logic [DATA_W-1:0]        rdata;
        logic [15:0]              acq_cnt;
        logic                     acquiring;
        logic                     lock_loss_monitor;
        logic                     los;
        logic [15:0]              los_cnt;
        logic [12:0]              win_cnt;
        logic [12:0]              fb_cnt;
        logic [BANKS-1:0][8:0]    div_cnt;
        logic [BANKS-1:0][7:0]    acc;
        logic [BANKS-1:0]         bank_out;
    } csc_dev_s_t;

    csc_dev_s_t                s_q;
    csc_dev_s_t                s_d;
    logic [DATA_W-1:0]         ram_mem [REG_COUNT];
    logic [DATA_W-1:0]         otp_mem [REG_COUNT];
    logic                      otp_used = 1'b0;
    logic                      ram_we;
    logic [ADDR_W-1:0]         ram_addr;
    logic [DATA_W-1:0]         ram_wdata;
    logic                      otp_we;
    logic [DATA_W-1:0]         status;

    function automatic logic [7:0] wr_mask(input logic [7:0] a);
        if (a == REG_STATUS) begin
            return MASK_NONE;
        end else if (a == REG_CTRL) begin
            return MASK_CTRL;
        end
        return MASK_FULL;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Live status, cause of the interrupt
    always_comb begin
        status               = '0;
        status[STS_ACQ_BIT]  = s_q.acquiring;
        status[STS_LOS_BIT]  = s_q.los;
        status[STS_LOL_BIT]  = s_q.lock_loss_monitor;
    end

    assign o_intr                 = s_q.acquiring | s_q.los | s_q.lock_loss_monitor;
    assign o_input_xtal           = ram_mem[REG_CTRL][CTRL_XTAL_BIT];
    assign o_lock_loss_monitor_en = ~ram_mem[REG_CTRL][CTRL_PAUSE_BIT];
    assign bus.ack                = s_q.ack;
    assign bus.err                = s_q.err;
    assign bus.rdata              = s_q.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [12:0]  diff;
        logic         sel_tick;
        logic [8:0]   period;
        logic [8:0]   sum;
        diff      = '0;
        sel_tick  = 1'b0;
        period    = '0;
        sum       = '0;
        s_d       = s_q;
        s_d.ack   = 1'b0;
        ram_we    = 1'b0;
        ram_addr  = s_q.idx;
        ram_wdata = otp_used ? otp_mem[s_q.idx] : '0;   // Blank store reads as zero
        otp_we    = 1'b0;

        // Lock acquisition timer; a command taken below reloads it
        if (s_q.acquiring) begin
            s_d.acq_cnt = s_q.acq_cnt - 16'h0001;
            if (s_q.acq_cnt == 16'h0001) begin
                s_d.acquiring = 1'b0;
            end
        end

        unique case (s_q.st)
            CSC_LOAD: begin
                ram_we = 1'b1;
                s_d.idx = s_q.idx + 8'h01;
                if (s_q.idx == 8'hFF) begin
                    s_d.st = CSC_RUN;
                end
            end
            CSC_BURN: begin
                otp_we  = 1'b1;
                s_d.idx = s_q.idx + 8'h01;
                if (s_q.idx == 8'hFF) begin
                    s_d.st  = CSC_RUN;
                    s_d.ack = 1'b1;
                    s_d.err = 1'b0;
                end
            end
            CSC_RUN: begin
                if (bus.req && !s_q.ack) begin
                    s_d.err = 1'b0;
                    if (bus.otp) begin
                        if (otp_used) begin
                            s_d.ack = 1'b1;
                            s_d.err = 1'b1;
                        end else begin
                            s_d.st  = CSC_BURN;
                            s_d.idx = '0;
                        end
                    end else if (bus.we) begin
                        s_d.ack   = 1'b1;
                        ram_we    = 1'b1;
                        ram_addr  = bus.addr;
                        ram_wdata = (ram_mem[bus.addr] & ~wr_mask(bus.addr))
                                  | (bus.wdata & wr_mask(bus.addr));
                        s_d.err   = (wr_mask(bus.addr) == MASK_NONE);
                        if (bus.addr == REG_CMD &&
                            (bus.wdata[CMD_RELOCK_BIT] || bus.wdata[CMD_CAL_BIT])) begin
                            s_d.acquiring = 1'b1;
                            s_d.acq_cnt   = 16'(ACQ_LEN);
                            s_d.lock_loss_monitor       = 1'b0;
                        end
                    end else begin
                        s_d.ack   = 1'b1;
                        s_d.rdata = (bus.addr == REG_STATUS) ? status
                                                             : ram_mem[bus.addr];
                    end
                end
            end
            default: begin
                s_d.st = CSC_LOAD;
            end
        endcase

        // Loss of signal on the selected input
        sel_tick = ram_mem[REG_CTRL][CTRL_XTAL_BIT] ? i_xtal_tick : i_ref_tick;
        if (sel_tick) begin
            s_d.los_cnt = '0;
            s_d.los     = 1'b0;
        end else if (s_q.los_cnt == 16'(LOS_LEN)) begin
            s_d.los = 1'b1;
        end else begin
            s_d.los_cnt = s_q.los_cnt + 16'h0001;
        end

        // Lock-loss monitor compares both detector inputs over a window
        if (!ram_mem[REG_CTRL][CTRL_PAUSE_BIT] && !s_q.acquiring && s_q.st == CSC_RUN) begin
            if (i_pfd_fb_tick && s_q.fb_cnt != 13'h1FFF) begin
                s_d.fb_cnt = s_q.fb_cnt + 13'h0001;
            end
            if (i_pfd_ref_tick) begin
                s_d.win_cnt = s_q.win_cnt + 13'h0001;
                if (s_q.win_cnt == 13'(LOL_WINDOW - 1)) begin
                    diff = (s_d.fb_cnt > 13'(LOL_WINDOW)) ? s_d.fb_cnt - 13'(LOL_WINDOW)
                                                          : 13'(LOL_WINDOW) - s_d.fb_cnt;
                    s_d.lock_loss_monitor     = (diff > 13'(LOL_THRESH));
                    s_d.win_cnt = '0;
                    s_d.fb_cnt  = '0;
                end
            end
        end else begin
            s_d.win_cnt = '0;
            s_d.fb_cnt  = '0;
        end

        // Fractional dividers, one per bank, driven straight from RAM
        for (int b = 0; b < BANKS; b++) begin
            if (s_q.st != CSC_RUN || ram_mem[REG_INT_DIV + 8'(b)] == 8'h00) begin
                s_d.div_cnt[b]  = '0;
                s_d.acc[b]      = '0;
                s_d.bank_out[b] = 1'b0;
            end else if (s_q.div_cnt[b] > 9'h001) begin
                s_d.div_cnt[b] = s_q.div_cnt[b] - 9'h001;
            end else begin
                s_d.bank_out[b] = ~s_q.bank_out[b];
                sum    = {1'b0, s_q.acc[b]} + {1'b0, ram_mem[REG_FRAC_NUM + 8'(b)]};
                period = {1'b0, ram_mem[REG_INT_DIV + 8'(b)]};
                if (ram_mem[REG_FRAC_DEN + 8'(b)] != 8'h00 &&
                    sum >= {1'b0, ram_mem[REG_FRAC_DEN + 8'(b)]}) begin
                    period = period + 9'h001;
                    sum    = sum - {1'b0, ram_mem[REG_FRAC_DEN + 8'(b)]};
                end
                s_d.acc[b]     = sum[7:0];
                s_d.div_cnt[b] = period;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers and memories
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (ram_we) begin
            ram_mem[ram_addr] <= ram_wdata;
        end
    end

    // Nonvolatile store: untouched by reset, sealed after one burn
    always_ff @(posedge i_sys_clk) begin
        if (otp_we) begin
            otp_mem[s_q.idx] <= ram_mem[s_q.idx];
            otp_used         <= 1'b1;
        end
    end

    for (genvar g = 0; g < BANKS * OUTS_PER_BANK; g++) begin : g_out
        assign o_bank_clk[g] = s_q.bank_out[g / OUTS_PER_BANK];
    end
endmodule

// ### hw/csc_host.sv
`timescale 1ns/1ps
module csc_host
    import csc_pkg::*;
#(
    parameter int POLL_LIMIT = POLL_MAX
) (
    input  wire logic                i_sys_clk,
    input  wire logic                i_reset_n,
    csc_cfg_if.host                  bus,
    input  wire logic                i_start,
    input  wire logic                i_burn,
    input  wire logic [7:0]          i_cfg_count,
    input  wire logic [ADDR_W-1:0]   i_cfg_addr,
    input  wire logic [DATA_W-1:0]   i_cfg_data,
    input  wire logic [DATA_W-1:0]   i_cfg_mask,
    output logic [7:0]               o_cfg_index,
    output logic                     o_busy,
    output logic                     o_done,
    output logic                     o_error
);
    initial begin
        if (POLL_LIMIT < 1 || POLL_LIMIT > 65535) begin
            $error("csc_host: POLL_LIMIT out of range");
        end
    end

    typedef enum logic [3:0] {
        H_IDLE, H_PAUSE_RD, H_PAUSE_WR, H_ENT_RD, H_ENT_WR, H_VALIDATE,
        H_RELOCK, H_WAIT_LOCK, H_RESTART_RD, H_RESTART_WR, H_CALIB, H_BURN
    } csc_host_state_t;

    typedef struct packed {
        csc_host_state_t    st;
        logic [7:0]         idx;
        logic [DATA_W-1:0]  wbuf;
        logic [15:0]        polls;
        logic               done;
        logic               error;
    } csc_host_s_t;

    csc_host_s_t        s_q;
    csc_host_s_t        s_d;
    logic [DATA_W-1:0]  m_mask;
    logic [DATA_W-1:0]  m_data;

    ////////////////////////////////////////////////////////////////////////////
    // Request generation
    always_comb begin
        bus.req   = (s_q.st != H_IDLE);
        bus.otp   = (s_q.st == H_BURN);
        bus.we    = s_q.st inside {H_PAUSE_WR, H_ENT_WR, H_RELOCK, H_RESTART_WR, H_CALIB};
        bus.wdata = s_q.wbuf;
        m_mask    = 8'h01 << CTRL_PAUSE_BIT;
        m_data    = (s_q.st == H_PAUSE_RD) ? m_mask : 8'h00;
        unique case (s_q.st)
            H_ENT_RD, H_ENT_WR: begin
                bus.addr = i_cfg_addr;
                m_mask   = i_cfg_mask;
                m_data   = i_cfg_data;
            end
            H_VALIDATE, H_WAIT_LOCK: bus.addr = REG_STATUS;
            H_RELOCK, H_CALIB:       bus.addr = REG_CMD;
            default:                 bus.addr = REG_CTRL;
        endcase
    end

    assign o_cfg_index = s_q.idx;
    assign o_busy      = (s_q.st != H_IDLE);
    assign o_done      = s_q.done;
    assign o_error     = s_q.error;

    ////////////////////////////////////////////////////////////////////////////
    // Reconfiguration sequence
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (bus.ack && bus.err && s_q.st != H_IDLE) begin
            s_d.st    = H_IDLE;
            s_d.error = 1'b1;
            s_d.done  = 1'b1;
        end else begin
            unique case (s_q.st)
                H_IDLE: begin
                    s_d.polls = '0;
                    s_d.idx   = '0;
                    if (i_burn) begin
                        s_d.st    = H_BURN;
                        s_d.error = 1'b0;
                    end else if (i_start) begin
                        s_d.st    = H_PAUSE_RD;
                        s_d.error = 1'b0;
                    end
                end
                H_PAUSE_RD, H_ENT_RD, H_RESTART_RD: begin
                    if (bus.ack) begin
                        s_d.wbuf = (bus.rdata & ~m_mask) | (m_data & m_mask);
                        s_d.st   = csc_host_state_t'(s_q.st + 4'h1);
                    end
                end
                H_PAUSE_WR: begin
                    if (bus.ack) begin
                        s_d.st = (i_cfg_count == 8'h00) ? H_VALIDATE : H_ENT_RD;
                    end
                end
                H_ENT_WR: begin
                    if (bus.ack) begin
                        s_d.idx = s_q.idx + 8'h01;
                        s_d.st  = (s_q.idx + 8'h01 == i_cfg_count) ? H_VALIDATE : H_ENT_RD;
                    end
                end
                H_VALIDATE, H_WAIT_LOCK: begin
                    if (bus.ack) begin
                        s_d.polls = s_q.polls + 16'h0001;
                        if (s_q.st == H_VALIDATE && !bus.rdata[STS_LOS_BIT]) begin
                            s_d.st    = H_RELOCK;
                            s_d.wbuf  = 8'h01 << CMD_RELOCK_BIT;
                            s_d.polls = '0;
                        end else if (s_q.st == H_WAIT_LOCK && !bus.rdata[STS_ACQ_BIT]
                                     && !bus.rdata[STS_LOL_BIT]) begin
                            s_d.st = H_RESTART_RD;
                        end else if (s_q.polls == 16'(POLL_LIMIT)) begin
                            s_d.st    = H_IDLE;
                            s_d.error = 1'b1;
                            s_d.done  = 1'b1;
                        end
                    end
                end
                H_RELOCK: begin
                    if (bus.ack) begin
                        s_d.st = H_WAIT_LOCK;
                    end
                end
                H_RESTART_WR: begin
                    if (bus.ack) begin
                        s_d.st   = H_CALIB;
                        s_d.wbuf = 8'h01 << CMD_CAL_BIT;
                    end
                end
                H_CALIB, H_BURN: begin
                    if (bus.ack) begin
                        s_d.st   = H_IDLE;
                        s_d.done = 1'b1;
                    end
                end
                default: s_d.st = H_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ### pkg/csc_cfg_if.sv
`timescale 1ns/1ps
interface csc_cfg_if;
    import csc_pkg::*;
    logic               req;
    logic               we;
    logic               otp;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
    logic               ack;
    logic               err;
    logic [DATA_W-1:0]  rdata;

    modport dev  (input req, we, otp, addr, wdata, output ack, err, rdata);
    modport host (output req, we, otp, addr, wdata, input ack, err, rdata);
endinterface

// ### pkg/csc_pkg.sv
package csc_pkg;
    // Register space and map
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          REG_COUNT       = 256;
    localparam int          BANKS           = 4;
    localparam int          OUTS_PER_BANK   = 2;
    localparam logic [7:0]  REG_INT_DIV     = 8'h08;
    localparam logic [7:0]  REG_FRAC_NUM    = 8'h0C;
    localparam logic [7:0]  REG_FRAC_DEN    = 8'h10;
    localparam logic [7:0]  REG_STATUS      = 8'hDA;
    localparam logic [7:0]  REG_CTRL        = 8'hE6;
    localparam logic [7:0]  REG_CMD         = 8'hE7;
    localparam logic [7:0]  MASK_FULL       = 8'hFF;
    localparam logic [7:0]  MASK_NONE       = 8'h00;
    localparam logic [7:0]  MASK_CTRL       = 8'h03;
    // Control, command and status bit positions
    localparam int          CTRL_PAUSE_BIT  = 0;
    localparam int          CTRL_XTAL_BIT   = 1;
    localparam int          CMD_RELOCK_BIT  = 0;
    localparam int          CMD_CAL_BIT     = 1;
    localparam int          STS_ACQ_BIT     = 0;
    localparam int          STS_LOS_BIT     = 2;
    localparam int          STS_LOL_BIT     = 3;
    // Timing
    localparam int          CLK_HZ          = 20_000_000;
    localparam int          ACQ_TIME_US     = 100;
    localparam int          ACQ_CYCLES      = ACQ_TIME_US * (CLK_HZ / 1_000_000);
    localparam int          LOS_TIME_NS     = 1000;
    localparam int          LOS_CYCLES      = LOS_TIME_NS / (1_000_000_000 / CLK_HZ);
    // Lock-loss monitor: window of reference ticks and 1000 ppm limit
    localparam int          LOL_WINDOW      = 4096;
    localparam int          LOL_PPM         = 1000;
    localparam int          LOL_THRESH      = (LOL_WINDOW * LOL_PPM) / 1_000_000;
    localparam int          POLL_MAX        = 1000;

    typedef enum logic [1:0] {
        CSC_LOAD,
        CSC_RUN,
        CSC_BURN
    } csc_dev_state_t;
endpackage

// ### verification/clock_synth_config_loader_tb_top.sv
`timescale 1ns/1ps
module clock_synth_config_loader_tb_top;
    import csc_pkg::*;
    logic       i_sys_clk = 1'h0;
    logic       i_reset_n = 1'h0;
    logic       start = 1'h0, burn = 1'h0, xtal_on = 1'h1, ref_on = 1'h1, fb_on = 1'h1;
    logic       xtal_tick = 1'h0, ref_tick = 1'h0, pfd_ref = 1'h0, pfd_fb = 1'h0;
    logic [1:0] tick_cnt = 2'h0;
    logic [7:0] cfg_count = 8'hD;
    logic [7:0] ent_addr [16], ent_data [16], ent_mask [16];
    logic [7:0] cfg_index;
    logic       busy, done, error, intr, input_xtal, lolm_en;
    logic [BANKS*OUTS_PER_BANK-1:0] bank_clk;
    int         num_errors = 0;
    int         cmp_count = 0;

    always #25 i_sys_clk = ~i_sys_clk;

    always @(posedge i_sys_clk) begin
        tick_cnt  <= tick_cnt + 2'h1;
        xtal_tick <= xtal_on && tick_cnt == 2'h0;
        ref_tick  <= ref_on && tick_cnt == 2'h2;
        pfd_ref   <= tick_cnt[0];
        pfd_fb    <= fb_on && tick_cnt[0];
    end

    csc_cfg_if bus_if ();
    csc_device #(.ACQ_LEN(40), .LOS_LEN(20)) u_csc_device (
        .i_sys_clk              (i_sys_clk),
        .i_reset_n              (i_reset_n),
        .bus                    (bus_if),
        .i_xtal_tick            (xtal_tick),
        .i_ref_tick             (ref_tick),
        .i_pfd_ref_tick         (pfd_ref),
        .i_pfd_fb_tick          (pfd_fb),
        .o_bank_clk             (bank_clk),
        .o_intr                 (intr),
        .o_input_xtal           (input_xtal),
        .o_lock_loss_monitor_en (lolm_en)
    );
    csc_host #(.POLL_LIMIT(60)) u_csc_host (
        .i_sys_clk   (i_sys_clk),
        .i_reset_n   (i_reset_n),
        .bus         (bus_if),
        .i_start     (start),
        .i_burn      (burn),
        .i_cfg_count (cfg_count),
        .i_cfg_addr  (ent_addr[cfg_index[3:0]]),
        .i_cfg_data  (ent_data[cfg_index[3:0]]),
        .i_cfg_mask  (ent_mask[cfg_index[3:0]]),
        .o_cfg_index (cfg_index),
        .o_busy      (busy),
        .o_done      (done),
        .o_error     (error)
    );
    csc_cfg_asserts u_csc_cfg_asserts (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .req       (bus_if.req),
        .we        (bus_if.we),
        .otp       (bus_if.otp),
        .addr      (bus_if.addr),
        .wdata     (bus_if.wdata),
        .ack       (bus_if.ack),
        .err       (bus_if.err),
        .rdata     (bus_if.rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(40_000 * 50);
        num_errors++;
        stop_test();
    end

    // Pulses start or burn and waits for the done pulse
    task automatic run_host(input logic b);
        @(posedge i_sys_clk);
        start <= ~b;
        burn  <= b;
        @(posedge i_sys_clk);
        start <= 1'h0;
        burn  <= 1'h0;
        for (int n = 0; n < 3000; n++) begin
            @(posedge i_sys_clk);
            if (done === 1'h1) break;
        end
        check(16'(done), 16'h1);
        check(16'(busy), 16'h0);
    endtask

    // Cycles spanned by four half periods of a bank, pair kept equal
    task automatic measure(input int b, input int exp);
        int   t, cyc, bad;
        logic last;
        t   = 0;
        cyc = 0;
        bad = 0;
        last = bank_clk[2*b];
        for (int n = 0; n < 200 && t < 5; n++) begin
            @(posedge i_sys_clk);
            if (t > 0) cyc++;
            if (bank_clk[2*b] !== last) t++;
            last = bank_clk[2*b];
            if (bank_clk[2*b] !== bank_clk[2*b+1]) bad++;
        end
        check(16'(cyc), 16'(exp));
        check(16'(bad), 16'h0);
    endtask

    task automatic t_config();
        run_host(1'h0);
        check(16'(error), 16'h0);
        check(16'(input_xtal), 16'h1);
        check(16'(lolm_en), 16'h1);
        measure(0, 4);
        measure(1, 8);
        measure(2, 12);
        measure(3, 10);
        $display("test config end");
    endtask

    task automatic t_los();
        ref_on <= 1'h0;
        run_host(1'h0);
        check(16'(error), 16'h0);
        xtal_on <= 1'h0;
        ref_on  <= 1'h1;
        run_host(1'h0);
        check(16'(error), 16'h1);
        xtal_on <= 1'h1;
        run_host(1'h0);
        check(16'(error), 16'h0);
        $display("test input end");
    endtask

    task automatic t_lol();
        // Let the calibration window close so intr shows only lock loss
        for (int n = 0; n < 200 && intr !== 1'h0; n++) begin
            @(posedge i_sys_clk);
        end
        check(16'(intr), 16'h0);
        fb_on <= 1'h0;
        for (int n = 0; n < 9000; n++) begin
            @(posedge i_sys_clk);
            if (intr === 1'h1) break;
        end
        check(16'(intr), 16'h1);
        fb_on <= 1'h1;
        run_host(1'h0);
        repeat (60) @(posedge i_sys_clk);
        check(16'(error), 16'h0);
        check(16'(intr), 16'h0);
        $display("test lock end");
    endtask

    task automatic t_burn();
        run_host(1'h1);
        check(16'(error), 16'h0);
        run_host(1'h1);
        check(16'(error), 16'h1);
        i_reset_n <= 1'h0;
        repeat (3) @(posedge i_sys_clk);
        i_reset_n <= 1'h1;
        repeat (270) @(posedge i_sys_clk);
        check(16'(input_xtal), 16'h1);
        check(16'(lolm_en), 16'h1);
        measure(3, 10);
        run_host(1'h1);
        check(16'(error), 16'h1);
        $display("test burn end");
    endtask

    initial begin
        for (int i = 0; i < 16; i++) begin
            ent_addr[i] = REG_CTRL;
            ent_data[i] = 8'h02;
            ent_mask[i] = 8'h02;
        end
        for (int i = 0; i < 4; i++) begin
            ent_addr[i]   = REG_INT_DIV + 8'(i);
            ent_addr[i+4] = REG_FRAC_NUM + 8'(i);
            ent_addr[i+8] = REG_FRAC_DEN + 8'(i);
            ent_data[i]   = (i == 3) ? 8'h02 : 8'(i + 1);
            ent_data[i+4] = (i == 3) ? 8'h01 : 8'h00;
            ent_data[i+8] = (i == 3) ? 8'h02 : 8'h01;
            ent_mask[i]   = MASK_FULL;
            ent_mask[i+4] = MASK_FULL;
            ent_mask[i+8] = MASK_FULL;
        end
        repeat (3) @(posedge i_sys_clk);
        i_reset_n <= 1'h1;
        repeat (270) @(posedge i_sys_clk);
        t_config();
        t_los();
        t_lol();
        t_burn();
        stop_test();
    end
endmodule

// ### verification/csc_cfg_asserts.sv
`timescale 1ns/1ps
module csc_cfg_asserts
    import csc_pkg::*;
(
    input wire logic              i_sys_clk,
    input wire logic              i_reset_n,
    input wire logic              req,
    input wire logic              we,
    input wire logic              otp,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              ack,
    input wire logic              err,
    input wire logic [DATA_W-1:0] rdata
);
    logic              run_q;
    logic              pause_q;
    logic [ADDR_W-1:0] rd_addr_q;
    logic              wr;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    assign wr = req && we && !otp;

    // Tracks link activity, last read address and the pause bit as written
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            run_q     <= 1'h0;
            pause_q   <= 1'h0;
            rd_addr_q <= '0;
        end else if (ack && !otp) begin
            run_q <= 1'h1;
            if (!we) rd_addr_q <= addr;
            if (we && addr == REG_CTRL) pause_q <= wdata[CTRL_PAUSE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too wide");
    property p_rw_latency;
        run_q && req && !otp && !ack |=> ack;
    endproperty
    a_rw_latency: assert property (p_rw_latency) else $error("ack late");
    property p_burn_latency;
        req && otp && !ack |-> ##[1:257] ack;
    endproperty
    a_burn_latency: assert property (p_burn_latency) else $error("burn hung");
    property p_req_hold;
        req && !ack |=> req && $stable({we, otp, addr, wdata});
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    property p_rmw;
        wr && addr != REG_CMD |-> rd_addr_q == addr;
    endproperty
    a_rmw: assert property (p_rmw) else $error("write without read");
    property p_cfg_paused;
        wr && addr != REG_CTRL && addr != REG_CMD |-> pause_q;
    endproperty
    a_cfg_paused: assert property (p_cfg_paused) else $error("write unpaused");
    property p_relock_paused;
        wr && addr == REG_CMD && wdata[CMD_RELOCK_BIT] |-> pause_q;
    endproperty
    a_relock_paused: assert property (p_relock_paused) else $error("relock unpaused");
    property p_cal_resumed;
        wr && addr == REG_CMD && wdata[CMD_CAL_BIT] |-> !pause_q;
    endproperty
    a_cal_resumed: assert property (p_cal_resumed) else $error("cal while paused");
    property p_no_status_wr;
        wr |-> addr != REG_STATUS;
    endproperty
    a_no_status_wr: assert property (p_no_status_wr) else $error("status written");
    property p_rdata_hold;
        !ack |-> $stable(rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");

    c_write: cover property (wr && ack);
    c_burn: cover property (req && otp && ack);
    c_cal: cover property (wr && addr == REG_CMD && wdata[CMD_CAL_BIT] && ack);
endmodule
